// [rtl/dmacr_top.sv]
// dma channel control registers and a shared fixed-priority transfer engine
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module dmacr_top #(
  parameter int NUM_SRC = 256
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_SRC-1:0] event_pulse, // request events, one cycle each
  input wire logic [23:0] periph_offset,      // offset given by peripheral indirect mode
  output logic mem_req,                       // transfer bus request, held until mem_ack
  output logic mem_we,
  output logic mem_byte,
  output logic [23:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic [dmacr_pkg::NUM_CH-1:0] block_irq // one-cycle pulse per channel
);
  localparam int NC = dmacr_pkg::NUM_CH;

  // channel configuration storage, indexed by channel
  logic [15:0] con_reg [NC];
  logic [7:0] sel_reg [NC];
  logic [NC-1:0] force_reg;
  logic [23:0] fbb_reg [NC];
  logic [23:0] sbb_reg [NC];
  logic [15:0] pad_reg [NC];
  logic [13:0] cnt_reg [NC];
  // per channel run state
  logic [23:0] ofs_reg [NC];   // post-increment offset into buffer
  logic [13:0] done_reg [NC];  // transfers finished in current block
  logic [NC-1:0] pp_reg;       // 1 while second buffer is in use
  logic [NC-1:0] evt_reg;      // latched peripheral request
  logic [NC-1:0] wcol_reg;
  logic [NC-1:0] rcol_reg;
  logic [3:0] last_ch_reg;
  logic [23:0] last_addr_reg;
  // engine
  dmacr_pkg::dmacr_state_t state_reg;
  logic [3:0] ch_reg;          // channel being served
  logic [15:0] data_reg;       // word carried from read to write
  logic fin;                   // transfer of ch_reg completes this cycle
  logic blk_end;               // that transfer closes a block
  logic half_pt;               // that transfer reaches the midpoint

  // apb decode
  logic [3:0] a_ch;
  logic [2:0] a_reg;
  logic wr_en;
  assign a_ch = paddr[8:5];
  assign a_reg = paddr[4:2];
  assign wr_en = psel && penable && pwrite && mapped(paddr); // refused writes change nothing
  assign pready = 1'b1;  // zero wait states

  // mapped if a real channel or a real status word, upper address bits clear
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[11:9] == 3'h0) && (a[1:0] == 2'h0) &&
             ((a[8:5] < 4'(NC)) ||
              (a[8:5] == dmacr_pkg::STATUS_SLOT && a[4:2] <= dmacr_pkg::S_LADDR_LOW));
  endfunction : mapped

  assign pslverr = psel && penable && !mapped(paddr);

  // one channel is requesting when enabled and triggered by event or force
  logic [NC-1:0] want;
  always_comb begin
    for (int i = 0; i < NC; i++) begin
      want[i] = con_reg[i][dmacr_pkg::B_ON] && (evt_reg[i] || force_reg[i]);
    end
  end

  // fixed priority: lowest channel number wins, others stay pending
  logic [3:0] win;
  logic any;
  always_comb begin
    win = 4'h0;
    any = 1'b0;
    for (int i = NC - 1; i >= 0; i--) begin
      if (want[i]) begin
        win = 4'(i);
        any = 1'b1;
      end
    end
  end

  // ram address of the served channel for the current transfer
  logic [23:0] ram_addr;
  logic [15:0] cc;
  always_comb begin
    cc = con_reg[ch_reg];
    ram_addr = pp_reg[ch_reg] ? sbb_reg[ch_reg] : fbb_reg[ch_reg];
    unique case (cc[5:4])
      dmacr_pkg::AM_POSTINC: ram_addr = ram_addr + ofs_reg[ch_reg];
      dmacr_pkg::AM_PERIND: ram_addr = ram_addr + periph_offset;
      default: ram_addr = ram_addr; // no increment; reserved code acts alike
    endcase
  end

  logic [23:0] src_addr;
  logic [23:0] dst_addr;
  assign src_addr = cc[dmacr_pkg::B_WAY] ? ram_addr : {8'h00, pad_reg[ch_reg]};
  assign dst_addr = cc[dmacr_pkg::B_WAY] ? {8'h00, pad_reg[ch_reg]} : ram_addr;

  assign fin = mem_ack && (state_reg == dmacr_pkg::DMACR_NULL ||
               (state_reg == dmacr_pkg::DMACR_WRITE && !cc[dmacr_pkg::B_NULL]));
  assign blk_end = fin && (done_reg[ch_reg] == cnt_reg[ch_reg]);
  assign half_pt = fin && (done_reg[ch_reg] == (cnt_reg[ch_reg] >> 1));

  // transfer engine: read source, write destination, optional null write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= dmacr_pkg::DMACR_IDLE;
      ch_reg <= 4'h0;
      data_reg <= dmacr_pkg::RST16;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_byte <= 1'b0;
      mem_addr <= 24'h000000;
      mem_wdata <= dmacr_pkg::RST16;
    end else begin
      unique case (state_reg)
        dmacr_pkg::DMACR_IDLE: begin
          if (any) begin
            ch_reg <= win;
            state_reg <= dmacr_pkg::DMACR_READ;
          end
        end
        dmacr_pkg::DMACR_READ: begin
          // address settles one cycle after grant, so request is raised here
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_byte <= cc[dmacr_pkg::B_SIZE];
            mem_addr <= src_addr;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            data_reg <= mem_rdata;
            state_reg <= dmacr_pkg::DMACR_WRITE;
          end
        end
        dmacr_pkg::DMACR_WRITE: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= dst_addr;
            mem_wdata <= data_reg;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            if (cc[dmacr_pkg::B_NULL]) begin
              state_reg <= dmacr_pkg::DMACR_NULL;
            end else begin
              state_reg <= dmacr_pkg::DMACR_IDLE;
            end
          end
        end
        dmacr_pkg::DMACR_NULL: begin
          // null data to the peripheral after the ram write; software keeps way at 0
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= {8'h00, pad_reg[ch_reg]};
            mem_wdata <= dmacr_pkg::RST16;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            state_reg <= dmacr_pkg::DMACR_IDLE;
          end
        end
      endcase
    end
  end

  // per channel block progress, offsets and ping-pong side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pp_reg <= '0;
      for (int i = 0; i < NC; i++) begin
        ofs_reg[i] <= 24'h000000;
        done_reg[i] <= 14'h0000;
      end
    end else begin
      for (int i = 0; i < NC; i++) begin
        if (!con_reg[i][dmacr_pkg::B_ON]) begin
          // a disabled channel restarts from its first buffer
          ofs_reg[i] <= 24'h000000;
          done_reg[i] <= 14'h0000;
          pp_reg[i] <= 1'b0;
        end else if (fin && ch_reg == 4'(i)) begin
          if (blk_end) begin
            ofs_reg[i] <= 24'h000000;
            done_reg[i] <= 14'h0000;
            if (con_reg[i][dmacr_pkg::M_PINGPONG]) begin
              pp_reg[i] <= !pp_reg[i];
            end
          end else begin
            done_reg[i] <= done_reg[i] + 14'h0001;
            ofs_reg[i] <= ofs_reg[i] + (con_reg[i][dmacr_pkg::B_SIZE] ?
                          dmacr_pkg::STEP_BYTE : dmacr_pkg::STEP_WORD);
          end
        end
      end
    end
  end

  // block interrupt pulses toward the interrupt controller flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_irq <= '0;
    end else begin
      for (int i = 0; i < NC; i++) begin
        block_irq[i] <= (ch_reg == 4'(i)) &&
                        (con_reg[i][dmacr_pkg::B_HALF] ? half_pt : blk_end);
      end
    end
  end

  // latched event requests; a served request is consumed on completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_reg <= '0;
    end else begin
      for (int i = 0; i < NC; i++) begin
        if (!con_reg[i][dmacr_pkg::B_ON]) begin
          evt_reg[i] <= 1'b0;
        end else if (event_pulse[sel_reg[i]]) begin
          evt_reg[i] <= 1'b1; // new event beats completion
        end else if (fin && ch_reg == 4'(i) && !force_reg[i]) begin
          evt_reg[i] <= 1'b0;
        end
      end
    end
  end

  // software configuration, plus hardware clears of enable and force
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_reg <= '0;
      for (int i = 0; i < NC; i++) begin
        con_reg[i] <= dmacr_pkg::RST16;
        sel_reg[i] <= 8'h00;
        fbb_reg[i] <= 24'h000000;
        sbb_reg[i] <= 24'h000000;
        pad_reg[i] <= dmacr_pkg::RST16;
        cnt_reg[i] <= 14'h0000;
      end
    end else begin
      for (int i = 0; i < NC; i++) begin
        if (wr_en && a_ch == 4'(i)) begin
          unique case (a_reg)
            dmacr_pkg::R_CONTROL: con_reg[i] <= pwdata[15:0] & dmacr_pkg::CON_MASK;
            dmacr_pkg::R_REQSEL: sel_reg[i] <= pwdata[7:0];
            dmacr_pkg::R_FBB_HIGH: fbb_reg[i][23:16] <= pwdata[7:0];
            dmacr_pkg::R_FBB_LOW: fbb_reg[i][15:0] <= pwdata[15:0];
            dmacr_pkg::R_SBB_HIGH: sbb_reg[i][23:16] <= pwdata[7:0];
            dmacr_pkg::R_SBB_LOW: sbb_reg[i][15:0] <= pwdata[15:0];
            dmacr_pkg::R_PERIPH: pad_reg[i] <= pwdata[15:0];
            dmacr_pkg::R_COUNT: cnt_reg[i] <= pwdata[13:0];
          endcase
        end
        // one-shot stops after one block, or after the second with ping-pong
        if (blk_end && ch_reg == 4'(i) && con_reg[i][dmacr_pkg::M_ONESHOT] &&
            (!con_reg[i][dmacr_pkg::M_PINGPONG] || pp_reg[i])) begin
          con_reg[i][dmacr_pkg::B_ON] <= 1'b0;
        end
        // force: writing 1 sets, writing 0 is ignored
        if (wr_en && a_ch == 4'(i) && a_reg == dmacr_pkg::R_REQSEL &&
            pwdata[dmacr_pkg::B_FORCE]) begin
          force_reg[i] <= 1'b1;
        end else if (!con_reg[i][dmacr_pkg::B_ON] || (fin && ch_reg == 4'(i))) begin
          force_reg[i] <= 1'b0;
        end
      end
    end
  end

  // shared status: collisions set by hardware, cleared by writing 1; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcol_reg <= '0;
      rcol_reg <= '0;
    end else begin
      for (int i = 0; i < NC; i++) begin
        // register write to a channel that is mid-transfer
        if (wr_en && a_ch == 4'(i) && state_reg != dmacr_pkg::DMACR_IDLE && ch_reg == 4'(i)) begin
          wcol_reg[i] <= 1'b1;
        end else if (wr_en && a_ch == dmacr_pkg::STATUS_SLOT &&
                     a_reg == dmacr_pkg::S_WCOL && pwdata[i]) begin
          wcol_reg[i] <= 1'b0;
        end
        // forced and event requests pending together
        if (force_reg[i] && event_pulse[sel_reg[i]]) begin
          rcol_reg[i] <= 1'b1;
        end else if (wr_en && a_ch == dmacr_pkg::STATUS_SLOT &&
                     a_reg == dmacr_pkg::S_RCOL && pwdata[i]) begin
          rcol_reg[i] <= 1'b0;
        end
      end
    end
  end

  // last channel served and last ram address touched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_ch_reg <= 4'h0;
      last_addr_reg <= 24'h000000;
    end else if (fin) begin
      last_ch_reg <= ch_reg;
      last_addr_reg <= ram_addr;
    end
  end

  // read mux; narrow fields sit low, everything else reads zero
  always_comb begin
    prdata = 32'h00000000;
    if (psel && mapped(paddr)) begin
      if (a_ch == dmacr_pkg::STATUS_SLOT) begin
        unique case (a_reg)
          dmacr_pkg::S_WCOL: prdata[NC-1:0] = wcol_reg;
          dmacr_pkg::S_RCOL: prdata[NC-1:0] = rcol_reg;
          dmacr_pkg::S_PPST: prdata[NC-1:0] = pp_reg;
          dmacr_pkg::S_LAST_CH: prdata[3:0] = last_ch_reg;
          dmacr_pkg::S_LADDR_HIGH: prdata[7:0] = last_addr_reg[23:16];
          default: prdata[15:0] = last_addr_reg[15:0];
        endcase
      end else begin
        unique case (a_reg)
          dmacr_pkg::R_CONTROL: prdata[15:0] = con_reg[a_ch];
          dmacr_pkg::R_REQSEL: prdata[15:0] = {force_reg[a_ch], 7'h00, sel_reg[a_ch]};
          dmacr_pkg::R_FBB_HIGH: prdata[7:0] = fbb_reg[a_ch][23:16];
          dmacr_pkg::R_FBB_LOW: prdata[15:0] = fbb_reg[a_ch][15:0];
          dmacr_pkg::R_SBB_HIGH: prdata[7:0] = sbb_reg[a_ch][23:16];
          dmacr_pkg::R_SBB_LOW: prdata[15:0] = sbb_reg[a_ch][15:0];
          dmacr_pkg::R_PERIPH: prdata[15:0] = pad_reg[a_ch];
          dmacr_pkg::R_COUNT: prdata[13:0] = cnt_reg[a_ch];
        endcase
      end
    end
  end
endmodule : dmacr_top
`default_nettype wire

// [include/dmacr_pkg.sv]
// constants shared by the dma channel register block
package dmacr_pkg;
  localparam int NUM_CH = 15;
  localparam int ADDR_W = 24;
  localparam int CNT_W = 14;
  // byte offsets: channel stride 0x20, status group at channel slot 15
  localparam logic [3:0] STATUS_SLOT = 4'hF;
  localparam logic [2:0] R_CONTROL = 3'h0;
  localparam logic [2:0] R_REQSEL = 3'h1;
  localparam logic [2:0] R_FBB_HIGH = 3'h2;
  localparam logic [2:0] R_FBB_LOW = 3'h3;
  localparam logic [2:0] R_SBB_HIGH = 3'h4;
  localparam logic [2:0] R_SBB_LOW = 3'h5;
  localparam logic [2:0] R_PERIPH = 3'h6;
  localparam logic [2:0] R_COUNT = 3'h7;
  localparam logic [2:0] S_WCOL = 3'h0;
  localparam logic [2:0] S_RCOL = 3'h1;
  localparam logic [2:0] S_PPST = 3'h2;
  localparam logic [2:0] S_LAST_CH = 3'h3;
  localparam logic [2:0] S_LADDR_HIGH = 3'h4;
  localparam logic [2:0] S_LADDR_LOW = 3'h5;
  // control field positions
  localparam int B_ON = 15;
  localparam int B_SIZE = 14;
  localparam int B_WAY = 13;
  localparam int B_HALF = 12;
  localparam int B_NULL = 11;
  localparam int B_FORCE = 15;
  localparam logic [15:0] CON_MASK = 16'hF833;
  localparam logic [15:0] REQ_MASK = 16'h00FF;
  localparam logic [15:0] CNT_MASK = 16'h3FFF;
  localparam logic [15:0] RST16 = 16'h0000;
  // addressing modes
  localparam logic [1:0] AM_POSTINC = 2'h0;
  localparam logic [1:0] AM_NOINC = 2'h1;
  localparam logic [1:0] AM_PERIND = 2'h2;
  // operating mode bits: bit0 one-shot, bit1 ping-pong
  localparam int M_ONESHOT = 0;
  localparam int M_PINGPONG = 1;
  localparam logic [ADDR_W-1:0] STEP_BYTE = 24'h000001;
  localparam logic [ADDR_W-1:0] STEP_WORD = 24'h000002;
  typedef enum logic [1:0] {
    DMACR_IDLE = 2'b00,
    DMACR_READ = 2'b01,
    DMACR_WRITE = 2'b10,
    DMACR_NULL = 2'b11
  } dmacr_state_t;
endpackage : dmacr_pkg

// [dv/dmacr_top_props.sv]
// concurrent checks on the ports of the dma channel register block
`timescale 1ns/100ps
`default_nettype none
module dmacr_top_props #(
  parameter int NUM_SRC = 256
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_SRC-1:0] event_pulse,
  input wire logic [23:0] periph_offset,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_byte,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic [dmacr_pkg::NUM_CH-1:0] block_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // register slot inside a channel window
  wire logic [2:0] rsel = paddr[4:2];
  // read access phase aimed at a channel, not the status group
  wire logic ch_rd = psel && penable && !pwrite && paddr[11:9] == 3'h0 &&
    paddr[8:5] != dmacr_pkg::STATUS_SLOT;
  // source read of one unit completing
  sequence s_rd_done;
    mem_req && !mem_we && mem_ack;
  endsequence
  // one idle cycle, then the destination write is requested
  sequence s_write_leg;
    !mem_req ##1 (mem_req && mem_we);
  endsequence
  chk_upper_zero: assert property (
    psel && penable && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  chk_con_holes: assert property (
    ch_rd && rsel == dmacr_pkg::R_CONTROL |-> (prdata[15:0] & ~dmacr_pkg::CON_MASK) == 16'h0)
    else $error("control shows unused bits");
  chk_req_holes: assert property (
    ch_rd && rsel == dmacr_pkg::R_REQSEL |-> prdata[14:8] == 7'h00)
    else $error("request select shows unused bits");
  chk_base_high: assert property (
    ch_rd && (rsel == dmacr_pkg::R_FBB_HIGH || rsel == dmacr_pkg::R_SBB_HIGH)
    |-> prdata[15:8] == 8'h00)
    else $error("base high shows unused bits");
  chk_unmapped_err: assert property (
    psel && penable && paddr[11:9] != 3'h0 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_req_hold: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
    else $error("transfer request dropped or changed");
  chk_read_write: assert property (
    s_rd_done |=> s_write_leg)
    else $error("write leg does not follow read");
  chk_irq_cause: assert property (
    block_irq != 15'h0 |-> $past(mem_ack) && $past(mem_we))
    else $error("block interrupt without a finished write");
endmodule : dmacr_top_props
bind dmacr_top dmacr_top_props #(.NUM_SRC(NUM_SRC)) dmacr_top_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .event_pulse(event_pulse), .periph_offset(periph_offset), .mem_req(mem_req),
  .mem_we(mem_we), .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_ack(mem_ack), .mem_rdata(mem_rdata), .block_irq(block_irq));
`default_nettype wire

// [dv/dmacr_mem_model.sv]
// behavioural ram and peripheral space answering the transfer bus
`timescale 1ns/100ps
`default_nettype none
module dmacr_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [2:0] ack_delay, // wait states before acknowledge
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [2:0] wait_cnt; // cycles the open request has waited
  wire logic go = mem_req && !mem_ack && wait_cnt >= ack_delay; // answer now
  // acknowledge is a one-cycle pulse so one request never completes twice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      wait_cnt <= 3'h0;
    end else begin
      mem_ack <= go;
      wait_cnt <= (mem_req && !mem_ack && !go) ? wait_cnt + 3'h1 : 3'h0;
    end
  end
  // read data valid only with acknowledge; toggles otherwise so stale data shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rdata <= 16'hA5A5;
    end else if (go && !mem_we) begin
      mem_rdata <= {mem_addr[7:0], ~mem_addr[7:0]};
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : dmacr_mem_model
`default_nettype wire

// [dv/dma_channel_control_registers_tb.sv]
// self-checking bench: register map, transfers, priority and force
`timescale 1ns/100ps
`default_nettype none
module dma_channel_control_registers_tb;
  // one expected access on the transfer bus
  typedef struct packed {logic we; logic sz; logic [23:0] addr; logic [15:0] data;} dmacr_exp_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat; // rdat: last read data
  logic pready, pslverr, rerr, mem_req, mem_we, mem_byte, mem_ack;
  logic [255:0] event_pulse = '0; // request events
  logic [23:0] periph_offset = 24'h0, mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [14:0] block_irq;
  logic [2:0] ack_delay = 3'h0; // partner wait states
  logic [7:0] src;
  int err_count = 0, cmp_count = 0;
  dmacr_exp_t exp_q[$], e; // accesses still to come
  int irq_q[$]; // channels whose interrupt is due
  logic [15:0] reg_m [15][8] = '{default: '0}; // register model
  logic [23:0] cur_m [15]; // model ram pointer
  int done_m [15]; // units moved in this block
  logic pp_m [15]; // model buffer select
  localparam logic [15:0] MSK [8] = '{dmacr_pkg::CON_MASK, 16'h00FF, 16'h00FF, 16'hFFFF,
    16'h00FF, 16'hFFFF, 16'hFFFF, dmacr_pkg::CNT_MASK};
  // channel, mode, count, events for each transfer scenario
  int tch [4] = '{3, 5, 7, 14};
  logic [15:0] tcon [4] = '{16'h0001, 16'h7010, 16'h0822, 16'h4033};
  int tcnt [4] = '{2, 3, 1, 0};
  int tev [4] = '{3, 8, 4, 3};
  dmacr_top #(.NUM_SRC(256)) dmacr_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_pulse(event_pulse), .periph_offset(periph_offset),
    .mem_req(mem_req), .mem_we(mem_we), .mem_byte(mem_byte), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .block_irq(block_irq));
  dmacr_mem_model dmacr_mem_model_i (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .ack_delay(ack_delay), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  always #50 pclk = ~pclk;
  task check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, want);
    end
  endtask : check
  task finish_test;
    $display("mismatches %0d, comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // one apb transfer; held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // register write; enabling restarts the model at the first buffer
  task wr(input int ch, input int r, input logic [31:0] d);
    reg_m[ch][r] = d[15:0] & MSK[r];
    if (r == 0 && d[15]) begin
      cur_m[ch] = {reg_m[ch][2][7:0], reg_m[ch][3]};
      done_m[ch] = 0;
      pp_m[ch] = 1'b0;
    end
    apb(1'b1, 12'(ch * 32 + r * 4), d);
  endtask : wr
  task rd(input int ch, input int r);
    apb(1'b0, 12'(ch * 32 + r * 4), 32'h0);
    check(rdat, {16'h0, reg_m[ch][r]});
  endtask : rd
  // addresses and count first, enable last
  task setup(input int ch, input logic [15:0] con, input int cnt);
    periph_offset <= 24'($urandom & 32'hFFFF);
    for (int r = 2; r < 7; r++) wr(ch, r, $urandom);
    wr(ch, 7, cnt);
    wr(ch, 1, {24'h0, src});
    wr(ch, 0, {16'h0, con | 16'h8000});
  endtask : setup
  // expected accesses and interrupt of one unit moved by a channel
  task xfer(input int ch);
    logic [15:0] c;
    logic [23:0] ram, per, s, d;
    c = reg_m[ch][0];
    per = {8'h00, reg_m[ch][6]};
    ram = (c[5:4] == dmacr_pkg::AM_PERIND) ? cur_m[ch] + periph_offset : cur_m[ch];
    s = c[13] ? ram : per;
    d = c[13] ? per : ram;
    exp_q.push_back(dmacr_exp_t'{1'b0, c[14], s, 16'h0});
    exp_q.push_back(dmacr_exp_t'{1'b1, c[14], d, c[14] ? {8'h0, ~s[7:0]} : {s[7:0], ~s[7:0]}});
    if (c[11]) exp_q.push_back(dmacr_exp_t'{1'b1, c[14], per, 16'h0});
    if (c[5:4] == dmacr_pkg::AM_POSTINC) cur_m[ch] += c[14] ? 24'h1 : 24'h2;
    done_m[ch]++;
    if (c[12] ? done_m[ch] == reg_m[ch][7] / 2 + 1 : done_m[ch] == reg_m[ch][7] + 1) begin
      irq_q.push_back(ch);
    end
    if (done_m[ch] == reg_m[ch][7] + 1) begin
      done_m[ch] = 0;
      if (c[1]) pp_m[ch] = !pp_m[ch];
      cur_m[ch] = pp_m[ch] ? {reg_m[ch][4][7:0], reg_m[ch][5]} : {reg_m[ch][2][7:0], reg_m[ch][3]};
      if (c[0] && !(c[1] && pp_m[ch])) reg_m[ch][0][15] = 1'b0;
    end
  endtask : xfer
  task fire;
    @(posedge pclk);
    event_pulse[src] <= 1'b1;
    @(posedge pclk);
    event_pulse <= '0;
  endtask : fire
  // wait until all expected accesses and interrupts were seen
  task drain;
    int n;
    n = 0;
    while (exp_q.size() + irq_q.size() > 0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    repeat (4) @(posedge pclk);
    check(exp_q.size() + irq_q.size(), 0);
  endtask : drain
  // each finished access is compared with the next expected one
  always @(posedge pclk) begin
    if (presetn && mem_req && mem_ack) begin
      e = exp_q.size() ? exp_q.pop_front() : '1;
      check(mem_we, e.we);
      check(mem_byte, e.sz);
      check(mem_addr, e.addr);
      if (e.we) check(e.sz ? {8'h0, mem_wdata[7:0]} : mem_wdata, e.data);
    end
    if (presetn && block_irq !== 15'h0) begin
      check(block_irq, irq_q.size() ? 15'h1 << irq_q.pop_front() : 15'h0);
    end
  end
  initial begin
    repeat (30000) @(posedge pclk);
    err_count++;
    finish_test;
  end
  initial begin
    void'($urandom(32'h1DF5380B));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, then random data through every register of every channel
    for (int ch = 0; ch < 15; ch++) begin
      for (int r = 0; r < 8; r++) begin
        rd(ch, r);
        wr(ch, r, $urandom & 32'hFFFF7FFF);
        rd(ch, r);
      end
    end
    apb(1'b1, 12'h1F8, 32'hFFFF);
    apb(1'b0, 12'h1F8, 32'h0);
    check(rerr, 1'b1);
    check(rdat, 32'h0);
    // upper address bits set: refused, and the aliased channel register keeps its value
    apb(1'b1, 12'h204, 32'hFF);
    check(rerr, 1'b1);
    rd(0, 1);
    // every size, direction, addressing and operating mode
    for (int t = 0; t < 4; t++) begin
      src = 8'($urandom_range(255, 0));
      setup(tch[t], tcon[t], tcnt[t]);
      for (int k = 0; k < tev[t]; k++) begin
        ack_delay <= 3'($urandom_range(4, 0));
        if (reg_m[tch[t]][0][15]) xfer(tch[t]);
        fire;
        drain;
      end
      rd(tch[t], 0);
      wr(tch[t], 0, 32'h0);
    end
    // two channels on one event: lower number first
    src = 8'($urandom_range(255, 0));
    setup(9, 16'h0001, 0);
    setup(1, 16'h0001, 0);
    xfer(1);
    xfer(9);
    fire;
    drain;
    // forced unit with a slow partner; software clear is ignored
    ack_delay <= 3'h7;
    setup(2, 16'h0000, 1);
    xfer(2);
    apb(1'b1, 12'h044, {16'h0, 8'h80, src});
    apb(1'b1, 12'h044, {24'h0, src});
    apb(1'b0, 12'h044, 32'h0);
    check(rdat, {16'h0, 8'h80, src});
    drain;
    rd(2, 1);
    apb(1'b0, 12'h1E0, 32'h0);
    check(rdat, 32'h4);
    // last served channel and the ram address of its only unit
    apb(1'b0, 12'h1EC, 32'h0);
    check(rdat, 32'h2);
    apb(1'b0, 12'h1F0, 32'h0);
    check(rdat, {16'h0, reg_m[2][2]});
    apb(1'b0, 12'h1F4, 32'h0);
    check(rdat, {16'h0, reg_m[2][3]});
    finish_test;
  end
endmodule : dma_channel_control_registers_tb
`default_nettype wire
